/* File: inc/ifffc_defs.vh */
// Constants for the interrupt flag, fast interrupt and filter controller
`ifndef IFFFC_DEFS_VH
`define IFFFC_DEFS_VH

`define IFFFC_NIRQ        8
`define IFFFC_NPER        8
`define IFFFC_NSRC        16
`define IFFFC_IDW         4
`define IFFFC_LVW         4
`define IFFFC_PCW         32
`define IFFFC_PSWW        32

// Detection modes of an external pin
`define IFFFC_DET_LOW     2'h0
`define IFFFC_DET_FALL    2'h1
`define IFFFC_DET_RISE    2'h2
`define IFFFC_DET_BOTH    2'h3

// Sampling clock selection for the noise filter
`define IFFFC_DIVW        6
`define IFFFC_SMP_DIV1    2'h0
`define IFFFC_SMP_DIV8    2'h1
`define IFFFC_SMP_DIV32   2'h2
`define IFFFC_SMP_DIV64   2'h3
`define IFFFC_MASK_DIV1   6'h00
`define IFFFC_MASK_DIV8   6'h07
`define IFFFC_MASK_DIV32  6'h1F
`define IFFFC_MASK_DIV64  6'h3F

// Stable samples the filter needs before it passes a new level
`define IFFFC_FLT_LEN     3
`define IFFFC_FLT_ONES    3'h7
`define IFFFC_FLT_ZERO    3'h0
// Pins idle high, so the filter starts at the idle level
`define IFFFC_PIN_IDLE    1'h1

// Arbitration result packing: {valid, id, level}
`define IFFFC_ARBW        9
`define IFFFC_ARB_VLD     8
`define IFFFC_ARB_ID_HI   7
`define IFFFC_ARB_ID_LO   4
`define IFFFC_ARB_LV_HI   3
`define IFFFC_ARB_LV_LO   0
`define IFFFC_LVL_OFF     4'h0
`define IFFFC_LVL_TOP     4'hF

`endif

/* File: hdl/ifffc_filter.v */
// Three-sample digital noise filter for one interrupt pin
`include "ifffc_defs.vh"

module ifffc_filter (
   // Clock and reset
   input  wire clk,
   input  wire rst,
   // Control
   input  wire enable,
   input  wire sample,
   // Pin level in and filtered level out
   input  wire din,
   output reg  dout
);

   reg [`IFFFC_FLT_LEN-1:0] hist;

   always @(posedge clk) begin
      if (rst) begin
         hist <= {`IFFFC_FLT_LEN{`IFFFC_PIN_IDLE}};
         dout <= `IFFFC_PIN_IDLE;
      end else if (!enable) begin
         hist <= {`IFFFC_FLT_LEN{din}};
         dout <= din;
      end else if (sample) begin
         hist <= {hist[`IFFFC_FLT_LEN-2:0], din};
         // Only three equal samples in a row move the output
         if ({hist[`IFFFC_FLT_LEN-2:0], din} == `IFFFC_FLT_ONES) begin
            dout <= 1'h1;
         end else if ({hist[`IFFFC_FLT_LEN-2:0], din} == `IFFFC_FLT_ZERO) begin
            dout <= 1'h0;
         end
      end
   end

endmodule

/* File: hdl/ifffc_ctrl.v */
// Interrupt controller: flags, priority, fast interrupt backup, pin filters
`include "ifffc_defs.vh"

module ifffc_ctrl (
   // Clock and reset
   input  wire                                    clk,
   input  wire                                    rst,
   // External pins and their setup
   input  wire [`IFFFC_NIRQ-1:0]                  irq_pin,
   input  wire [2*`IFFFC_NIRQ-1:0]                irq_detect,
   input  wire [`IFFFC_NIRQ-1:0]                  irq_filter_en,
   input  wire [1:0]                              irq_sample_sel,
   input  wire                                    nmi_pin,
   input  wire                                    nmi_rise,
   input  wire                                    nmi_filter_en,
   input  wire [1:0]                              nmi_sample_sel,
   // Peripheral request lines and their setup
   input  wire [`IFFFC_NPER-1:0]                  per_req,
   input  wire [`IFFFC_NPER-1:0]                  per_edge,
   // Source setup
   input  wire [`IFFFC_LVW*`IFFFC_NSRC-1:0]       src_priority,
   input  wire [`IFFFC_NSRC-1:0]                  src_to_dte,
   input  wire                                    fast_en,
   input  wire [`IFFFC_IDW-1:0]                   fast_id,
   // CPU core side
   input  wire                                    status_word_interrupt_enable,
   input  wire [`IFFFC_LVW-1:0]                   cpu_ipl,
   input  wire [`IFFFC_PCW-1:0]                   cpu_pc,
   input  wire [`IFFFC_PSWW-1:0]                  cpu_psw,
   input  wire                                    cpu_ack,
   input  wire                                    fast_return,
   input  wire                                    nmi_ack,
   output reg                                     cpu_req,
   output reg  [`IFFFC_IDW-1:0]                   cpu_id,
   output reg  [`IFFFC_LVW-1:0]                   cpu_level,
   output reg                                     cpu_fast,
   output reg                                     nmi_req,
   output reg                                     fast_busy,
   output reg  [`IFFFC_PCW-1:0]                   backup_program_counter,
   output reg  [`IFFFC_PSWW-1:0]                  backup_status_word,
   output reg                                     restore_valid,
   // Transfer engine side
   input  wire                                    dte_ack,
   output reg                                     dte_req,
   output reg  [`IFFFC_IDW-1:0]                   dte_id,
   // Status
   output reg  [`IFFFC_NSRC-1:0]                  irq_status
);

   ////////////////////////////////////////////////////////////////////////
   // Highest non-zero level wins, lowest index on a tie
   function [`IFFFC_ARBW-1:0] ifffc_arb;
      input [`IFFFC_NSRC-1:0]             pend;
      input [`IFFFC_LVW*`IFFFC_NSRC-1:0]  prio;
      integer                             i;
      reg   [`IFFFC_LVW-1:0]              lv;
      begin
         ifffc_arb = {`IFFFC_ARBW{1'h0}};
         for (i = `IFFFC_NSRC - 1; i >= 0; i = i - 1) begin
            lv = prio[i*`IFFFC_LVW +: `IFFFC_LVW];
            if (pend[i] && lv != `IFFFC_LVL_OFF && lv >= ifffc_arb[`IFFFC_ARB_LV_HI:`IFFFC_ARB_LV_LO]) begin
               ifffc_arb = {1'h1, i[`IFFFC_IDW-1:0], lv};
            end
         end
      end
   endfunction

   function ifffc_tick;
      input [1:0]             sel;
      input [`IFFFC_DIVW-1:0] cnt;
      begin
         case (sel)
            `IFFFC_SMP_DIV1:  ifffc_tick = (cnt & `IFFFC_MASK_DIV1) == `IFFFC_MASK_DIV1;
            `IFFFC_SMP_DIV8:  ifffc_tick = (cnt & `IFFFC_MASK_DIV8) == `IFFFC_MASK_DIV8;
            `IFFFC_SMP_DIV32: ifffc_tick = (cnt & `IFFFC_MASK_DIV32) == `IFFFC_MASK_DIV32;
            default:          ifffc_tick = (cnt & `IFFFC_MASK_DIV64) == `IFFFC_MASK_DIV64;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Sampling clock divider and pin filters
   reg  [`IFFFC_DIVW-1:0] div_cnt;
   wire                   irq_tick;
   wire                   nmi_tick;
   wire [`IFFFC_NIRQ-1:0] irq_flt;
   wire                   nmi_flt;

   always @(posedge clk) begin
      if (rst) begin
         div_cnt <= {`IFFFC_DIVW{1'h0}};
      end else begin
         div_cnt <= div_cnt + {{(`IFFFC_DIVW-1){1'h0}}, 1'h1};
      end
   end

   assign irq_tick = ifffc_tick(irq_sample_sel, div_cnt);
   assign nmi_tick = ifffc_tick(nmi_sample_sel, div_cnt);

   genvar g;
   generate
      for (g = 0; g < `IFFFC_NIRQ; g = g + 1) begin : g_irq_flt
         ifffc_filter u_flt (
            .clk    (clk),
            .rst    (rst),
            .enable (irq_filter_en[g]),
            .sample (irq_tick),
            .din    (irq_pin[g]),
            .dout   (irq_flt[g])
         );
      end
   endgenerate

   ifffc_filter u_nmi_flt (
      .clk    (clk),
      .rst    (rst),
      .enable (nmi_filter_en),
      .sample (nmi_tick),
      .din    (nmi_pin),
      .dout   (nmi_flt)
   );

   ////////////////////////////////////////////////////////////////////////
   // Source detection
   reg  [`IFFFC_NIRQ-1:0] irq_prev;
   reg  [`IFFFC_NPER-1:0] per_prev;
   reg                    nmi_prev;
   reg  [`IFFFC_NSRC-1:0] src_level;
   reg  [`IFFFC_NSRC-1:0] src_set;
   integer                k;

   always @* begin
      src_level = {`IFFFC_NSRC{1'h0}};
      src_set   = {`IFFFC_NSRC{1'h0}};
      for (k = 0; k < `IFFFC_NIRQ; k = k + 1) begin
         case (irq_detect[2*k +: 2])
            `IFFFC_DET_LOW: begin
               src_level[k] = 1'h1;
               src_set[k]   = !irq_flt[k];
            end
            `IFFFC_DET_FALL: src_set[k] = irq_prev[k] && !irq_flt[k];
            `IFFFC_DET_RISE: src_set[k] = !irq_prev[k] && irq_flt[k];
            default:         src_set[k] = irq_prev[k] != irq_flt[k];
         endcase
      end
      for (k = 0; k < `IFFFC_NPER; k = k + 1) begin
         src_level[`IFFFC_NIRQ+k] = !per_edge[k];
         src_set[`IFFFC_NIRQ+k]   = per_edge[k] ? (per_req[k] && !per_prev[k]) : per_req[k];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Arbitration
   wire [`IFFFC_NSRC-1:0]  fast_mask;
   wire [`IFFFC_NSRC-1:0]  cpu_pend;
   wire [`IFFFC_NSRC-1:0]  dte_pend;
   wire [`IFFFC_ARBW-1:0]  cpu_win;
   wire [`IFFFC_ARBW-1:0]  dte_win;
   wire                    fast_win;
   wire                    ord_win;
   wire [`IFFFC_NSRC-1:0]  cpu_clr;
   wire [`IFFFC_NSRC-1:0]  dte_clr;
   wire                    cpu_take;
   wire                    dte_take;

   assign fast_mask = fast_en ? ({{(`IFFFC_NSRC-1){1'h0}}, 1'h1} << fast_id) : {`IFFFC_NSRC{1'h0}};
   assign cpu_pend  = irq_status & ~src_to_dte & ~fast_mask;
   assign dte_pend  = irq_status & src_to_dte & ~fast_mask;
   assign cpu_win   = ifffc_arb(cpu_pend, src_priority);
   assign dte_win   = ifffc_arb(dte_pend, src_priority);
   // A second fast request waits: the single backup stage is in use
   assign fast_win  = |(irq_status & fast_mask) && !fast_busy;
   assign ord_win   = cpu_win[`IFFFC_ARB_VLD] && cpu_win[`IFFFC_ARB_LV_HI:`IFFFC_ARB_LV_LO] > cpu_ipl;
   assign cpu_take  = cpu_ack && cpu_req;
   assign dte_take  = dte_ack && dte_req;
   assign cpu_clr   = cpu_take ? ({{(`IFFFC_NSRC-1){1'h0}}, 1'h1} << cpu_id) : {`IFFFC_NSRC{1'h0}};
   assign dte_clr   = dte_take ? ({{(`IFFFC_NSRC-1){1'h0}}, 1'h1} << dte_id) : {`IFFFC_NSRC{1'h0}};

   ////////////////////////////////////////////////////////////////////////
   // Flags, requests and fast context
   always @(posedge clk) begin
      if (rst) begin
         irq_prev               <= {`IFFFC_NIRQ{`IFFFC_PIN_IDLE}};
         per_prev               <= {`IFFFC_NPER{1'h0}};
         nmi_prev               <= `IFFFC_PIN_IDLE;
         irq_status             <= {`IFFFC_NSRC{1'h0}};
         nmi_req                <= 1'h0;
         cpu_req                <= 1'h0;
         cpu_id                 <= {`IFFFC_IDW{1'h0}};
         cpu_level              <= `IFFFC_LVL_OFF;
         cpu_fast               <= 1'h0;
         dte_req                <= 1'h0;
         dte_id                 <= {`IFFFC_IDW{1'h0}};
         fast_busy              <= 1'h0;
         backup_program_counter <= {`IFFFC_PCW{1'h0}};
         backup_status_word     <= {`IFFFC_PSWW{1'h0}};
         restore_valid          <= 1'h0;
      end else begin
         irq_prev <= irq_flt;
         per_prev <= per_req;
         nmi_prev <= nmi_flt;
         // Level flags mirror the source; edge flags hold until acknowledged, set wins
         irq_status <= (src_level & src_set) |
                       (~src_level & (src_set | (irq_status & ~cpu_clr & ~dte_clr)));
         nmi_req <= (nmi_rise ? (!nmi_prev && nmi_flt) : (nmi_prev && !nmi_flt)) || (nmi_req && !nmi_ack);
         // Requests drop for a cycle after an acknowledge so a stale id is never re-sent
         if (cpu_take || !status_word_interrupt_enable) begin
            cpu_req <= 1'h0;
         end else begin
            cpu_req   <= fast_win || ord_win;
            cpu_fast  <= fast_win;
            cpu_id    <= fast_win ? fast_id : cpu_win[`IFFFC_ARB_ID_HI:`IFFFC_ARB_ID_LO];
            cpu_level <= fast_win ? `IFFFC_LVL_TOP : cpu_win[`IFFFC_ARB_LV_HI:`IFFFC_ARB_LV_LO];
         end
         if (dte_take) begin
            dte_req <= 1'h0;
         end else begin
            dte_req <= dte_win[`IFFFC_ARB_VLD];
            dte_id  <= dte_win[`IFFFC_ARB_ID_HI:`IFFFC_ARB_ID_LO];
         end
         restore_valid <= 1'h0;
         if (cpu_take && cpu_fast) begin
            backup_program_counter <= cpu_pc;
            backup_status_word     <= cpu_psw;
            fast_busy              <= 1'h1;
         end else if (fast_return && fast_busy) begin
            restore_valid <= 1'h1;
            fast_busy     <= 1'h0;
         end
      end
   end

endmodule

/* File: bench/ifffc_props_properties.sv */
// Port-level checks on the interrupt controller, bound into every instance
`include "ifffc_defs.vh"

module ifffc_props (
   // Clock and reset
   input wire                   clk,
   input wire                   rst,
   // CPU core side
   input wire                   status_word_interrupt_enable,
   input wire [`IFFFC_LVW-1:0]  cpu_ipl,
   input wire [`IFFFC_PCW-1:0]  cpu_pc,
   input wire [`IFFFC_PSWW-1:0] cpu_psw,
   input wire                   cpu_ack,
   input wire                   fast_return,
   input wire                   cpu_req,
   input wire [`IFFFC_LVW-1:0]  cpu_level,
   input wire                   cpu_fast,
   input wire                   fast_busy,
   input wire [`IFFFC_PCW-1:0]  backup_program_counter,
   input wire [`IFFFC_PSWW-1:0] backup_status_word,
   input wire                   restore_valid,
   // Transfer engine side
   input wire                   dte_ack,
   input wire                   dte_req
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   a_cpu_ack_drop: assert property (cpu_ack && cpu_req |=> !cpu_req)
      else $error("cpu request held after ack");
   a_dte_ack_drop: assert property (dte_ack && dte_req |=> !dte_req)
      else $error("engine request held after ack");
   a_cpu_gated: assert property ($rose(cpu_req) |-> $past(status_word_interrupt_enable))
      else $error("cpu request while interrupts disabled");
   a_level_above: assert property ($rose(cpu_req) && !cpu_fast |-> cpu_level > $past(cpu_ipl))
      else $error("forwarded level not above cpu level");
   a_fast_top: assert property (cpu_req && cpu_fast |-> cpu_level == `IFFFC_LVL_TOP)
      else $error("fast request not at top level");
   a_fast_save: assert property (cpu_ack && cpu_req && cpu_fast && !fast_busy |=> fast_busy &&
      backup_program_counter == $past(cpu_pc) && backup_status_word == $past(cpu_psw))
      else $error("fast context not saved");
   a_backup_kept: assert property (fast_busy && !fast_return |=>
      $stable(backup_program_counter) && $stable(backup_status_word))
      else $error("saved context overwritten");
   a_restore_pulse: assert property (fast_return && fast_busy |=>
      restore_valid && !fast_busy ##1 !restore_valid)
      else $error("restore not a single pulse");
   a_restore_cause: assert property (restore_valid |-> $past(fast_return) && $past(fast_busy))
      else $error("restore without fast return");
   c_fast: cover property (cpu_ack && cpu_req && cpu_fast);
   c_restore: cover property (restore_valid);
   c_engine: cover property (dte_ack && dte_req);
endmodule

bind ifffc_ctrl ifffc_props u_props (.*);

/* File: bench/ifffc_engine.sv */
// Model of the CPU core and transfer engine that accept forwarded requests
module ifffc_engine (
   // Clock and reset
   input  wire  clk,
   input  wire  rst,
   // Requests, and pace: slow acks only every fourth cycle
   input  wire  cpu_req,
   input  wire  cpu_fast,
   input  wire  dte_req,
   input  wire  slow,
   // Answers
   output logic cpu_ack,
   output logic dte_ack,
   output logic fast_return
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] pace;
   logic [4:0] hold;
   wire        go = !slow || pace == 2'h3;
   always @(posedge clk) begin
      pace        <= rst ? 2'h0 : pace + 2'h1;
      hold        <= rst ? 5'h00 : cpu_ack && cpu_req && cpu_fast ? 5'h14 : hold - 5'(hold != 5'h00);
      // Ack once, only while the request still stands
      cpu_ack     <= !rst && cpu_req && !cpu_ack && go;
      dte_ack     <= !rst && dte_req && !dte_ack && go;
      fast_return <= !rst && hold == 5'h01;
   end
endmodule

/* File: bench/interrupt_flag_fast_filter_ctrl_tb.sv */
// Self-checking bench for the interrupt flag, fast interrupt and filter controller
module interrupt_flag_fast_filter_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst = 1'b1, slow = 1'b0, fast_en = 1'b0, nmi_ack = 1'b0;
   logic        status_word_interrupt_enable = 1'b1, nmi_pin = 1'b1, nmi_rise = 1'b0, nmi_filter_en = 1'b1;
   logic [7:0]  irq_pin = 8'hFF, irq_filter_en = 8'h00, per_req = 8'h00, per_edge = 8'h00;
   logic [15:0] irq_detect = 16'h00E4, src_to_dte = 16'h0100, irq_status;
   logic [63:0] src_priority = 64'h0000_0007_0000_5432;
   logic [31:0] cpu_pc = 32'h0, cpu_psw = 32'h0, backup_program_counter, backup_status_word;
   logic [3:0]  cpu_ipl = 4'hF, fast_id = 4'h6, cpu_id, cpu_level, dte_id;
   logic [1:0]  irq_sample_sel = 2'h0, nmi_sample_sel = 2'h0;
   logic        cpu_ack, fast_return, dte_ack, cpu_req, cpu_fast, nmi_req, fast_busy, restore_valid, dte_req;
   logic [4:0]  exp_q[$];
   int          err_count = 0, check_count = 0, cycles = 0, dv[4] = '{1, 8, 32, 64};
   ifffc_ctrl   dut (.*);
   ifffc_engine engine (.*);
   initial forever #4 clk = ~clk;
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Every wait passes here, so the cycle ceiling also cuts a hang short
   task automatic tick(input int n);
      repeat (n) begin
         @(negedge clk);
         cpu_pc = $urandom;
         cpu_psw = $urandom;
         if (++cycles == 5000) begin
            err_count++;
            report_and_stop();
         end
      end
   endtask
   task automatic flt(input int lo, input int hi, input logic [1:0] exp);
      {irq_pin[4], nmi_pin} = 2'h0;
      tick(lo);
      chk({irq_status[4], nmi_req}, exp);
      {irq_pin[4], nmi_pin} = 2'h3;
      nmi_ack = exp[0];
      tick(1);
      nmi_ack = 1'b0;
      tick(hi);
      chk({irq_status[4], nmi_req}, 2'h0);
   endtask
   // Each accepted cpu request takes the oldest expected {fast, id} note; engine requests must carry id 8
   always @(posedge clk) begin
      if (!rst && cpu_ack && cpu_req)
         chk({cpu_fast, cpu_id}, exp_q.size() > 0 ? exp_q.pop_front() : 16'hFFFF);
      if (!rst && dte_ack && dte_req)
         chk(dte_id, 4'h8);
   end
   initial begin
      void'($urandom(32'h37bfc126));
      tick(16);
      rst = 1'b0;
      chk({cpu_req, dte_req, nmi_req, fast_busy, restore_valid}, 16'h0);
      // Pins 0..3 in modes low, falling, rising, both; top cpu level holds requests back
      irq_pin[3:0] = 4'h0;
      tick(4);
      chk(irq_status[3:0], 4'hB);
      irq_pin[3:0] = 4'hF;
      tick(4);
      chk(irq_status[3:0], 4'hE);
      exp_q = '{5'h03, 5'h02, 5'h01};
      slow = 1'($urandom);
      cpu_ipl = 4'h0;
      tick(30);
      chk(irq_status[3:0], 4'h0);
      chk(exp_q.size(), 16'h0);
      // Source 8 is level type, source 9 rising-edge type with priority 0, so its flag is never acknowledged
      per_req = 8'h03;
      per_edge[1] = 1'b1;
      tick(12);
      chk(irq_status[8], 1'b1);
      per_req = 8'h00;
      tick(4);
      chk(irq_status[8], 1'b0);
      chk(irq_status[9], 1'b1);
      // Fast source 6 at level 1 beats pin 7 at level F; a second edge waits for the return
      status_word_interrupt_enable = 1'b0;
      fast_en = 1'b1;
      slow = 1'($urandom);
      src_priority = 64'hF100_0000;
      irq_detect = 16'h5000;
      irq_pin[7:6] = 2'h0;
      tick(6);
      chk(cpu_req, 1'b0);
      exp_q = '{5'h16, 5'h07, 5'h16};
      status_word_interrupt_enable = 1'b1;
      tick(6);
      irq_pin[6] = 1'b1;
      tick(2);
      irq_pin[6] = 1'b0;
      tick(80);
      chk(exp_q.size(), 16'h0);
      chk(fast_busy, 1'b0);
      cpu_ipl = 4'hF;
      src_priority = 64'h0001_0000;
      irq_filter_en = 8'h10;
      for (int s = 0; s < 4; s++) begin
         irq_sample_sel = 2'(s);
         nmi_sample_sel = 2'(s);
         // Exactly two samples low: a filter shorter than three would pass this
         flt(2 * dv[s], 5 * dv[s], 2'h0);
         flt(5 * dv[s] + 4, 5 * dv[s] + 4, 2'h3);
      end
      // Rising-edge NMI mode with the filter bypassed
      {nmi_rise, nmi_filter_en, nmi_pin} = 3'h4;
      tick(4);
      chk(nmi_req, 1'b0);
      nmi_pin = 1'b1;
      tick(4);
      chk(nmi_req, 1'b1);
      report_and_stop();
   end
endmodule
